// file: src/bbt_bridge.sv
`timescale 1ns/1ps
module bbt_bridge (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Processor side
    input  wire logic             cpu_valid_i,
    input  wire bbt_pkg::bbt_req_t cpu_req_i,
    output logic                  cpu_ready_o,
    output logic                  cpu_done_o,
    output logic [31:0]           cpu_rdata_o,
    // Memory side
    output logic                  mem_valid_o,
    output bbt_pkg::bbt_req_t     mem_req_o,
    output logic                  mem_lock_o,
    input  wire logic             mem_ready_i,
    input  wire logic             mem_done_i,
    input  wire logic [31:0]      mem_rdata_i
);

    bbt_pkg::bbt_state_t state;
    bbt_pkg::bbt_req_t   req;
    logic [2:0]          bit_sel;
    logic                is_alias;
    logic [31:0]         band_addr;
    logic [4:0]          lane_bit;
    logic [31:0]         mask;
    logic [31:0]         next_wdata;

    // Alias window is 0x2200_0000..0x23FF_FFFF; fetches are not remapped
    assign is_alias = (cpu_req_i.addr[31:25] == bbt_pkg::ALIAS_BASE[31:25])
                      && !cpu_req_i.instr;

    // Inverse of base + byte*32 + bit*4
    assign band_addr = bbt_pkg::BAND_BASE
        | {12'h000, req.addr[bbt_pkg::BYTE_LSB +: bbt_pkg::BYTE_W]};
    assign bit_sel = req.addr[bbt_pkg::BIT_LSB +: bbt_pkg::BIT_W];

    // Little-endian lane: byte at offset k occupies bits 8k+7..8k
    assign lane_bit = {band_addr[1:0], bit_sel};
    assign mask = 32'h0000_0001 << lane_bit;
    assign next_wdata = req.wdata[0] ? (mem_rdata_i | mask)
                                     : (mem_rdata_i & ~mask);

    assign cpu_ready_o = (state == bbt_pkg::BBT_IDLE);
    assign mem_valid_o = (state != bbt_pkg::BBT_IDLE);
    assign mem_lock_o  = (state == bbt_pkg::BBT_RD)
                         || (state == bbt_pkg::BBT_WB);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= bbt_pkg::BBT_IDLE;
        end else begin
            case (state)
                bbt_pkg::BBT_IDLE: begin
                    if (cpu_valid_i) begin
                        state <= is_alias ? bbt_pkg::BBT_RD : bbt_pkg::BBT_PASS;
                    end
                end
                bbt_pkg::BBT_PASS: begin
                    if (mem_done_i) begin
                        state <= bbt_pkg::BBT_IDLE;
                    end
                end
                bbt_pkg::BBT_RD: begin
                    if (mem_done_i) begin
                        state <= req.write ? bbt_pkg::BBT_WB
                                           : bbt_pkg::BBT_IDLE;
                    end
                end
                bbt_pkg::BBT_WB: begin
                    if (mem_done_i) begin
                        state <= bbt_pkg::BBT_IDLE;
                    end
                end
                default: state <= bbt_pkg::BBT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req <= '0;
        end else if (state == bbt_pkg::BBT_IDLE && cpu_valid_i) begin
            req <= cpu_req_i;
        end
    end

    // Memory request: alias accesses keep size, address goes to band byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_req_o <= '0;
        end else if (state == bbt_pkg::BBT_IDLE && cpu_valid_i) begin
            mem_req_o <= cpu_req_i;
            if (is_alias) begin
                mem_req_o.addr  <= bbt_pkg::BAND_BASE
                    | {12'h000, cpu_req_i.addr[bbt_pkg::BYTE_LSB +:
                                               bbt_pkg::BYTE_W]};
                mem_req_o.write <= 1'b0;
                mem_req_o.size  <= cpu_req_i.size;
            end
        end else if (state == bbt_pkg::BBT_RD && mem_done_i && req.write) begin
            mem_req_o.write <= 1'b1;
            mem_req_o.wdata <= next_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_done_o  <= 1'b0;
            cpu_rdata_o <= 32'h0000_0000;
        end else begin
            cpu_done_o <= 1'b0;
            if (mem_done_i && state == bbt_pkg::BBT_PASS) begin
                cpu_done_o  <= 1'b1;
                cpu_rdata_o <= mem_rdata_i;
            end else if (mem_done_i && state == bbt_pkg::BBT_RD
                         && !req.write) begin
                cpu_done_o  <= 1'b1;
                cpu_rdata_o <= {31'h0, mem_rdata_i[lane_bit]};
            end else if (mem_done_i && state == bbt_pkg::BBT_WB) begin
                cpu_done_o  <= 1'b1;
                cpu_rdata_o <= 32'h0000_0000;
            end
        end
    end

    // Checks
    a_read_value: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        cpu_done_o && $past(state) == bbt_pkg::BBT_RD |->
        cpu_rdata_o[31:1] == 31'h0)
        else $error("alias read returned more than bit 0");

    a_lock_held: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_RD && mem_done_i && req.write |=>
        mem_lock_o && state == bbt_pkg::BBT_WB)
        else $error("lock dropped between read and write-back");

    a_wb_one_bit: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_RD && mem_done_i && req.write |=>
        ((mem_req_o.wdata ^ $past(mem_rdata_i))
         & ~(32'h0000_0001 << $past(req.addr[6:2]))) == 32'h0000_0000)
        else $error("write-back touched other bits");

    a_wb_bit_val: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_RD && mem_done_i && req.write |=>
        mem_req_o.wdata[$past(req.addr[6:2])] == $past(req.wdata[0]))
        else $error("target bit not taken from data bit 0");

    a_alias_addr: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i && is_alias |=>
        mem_req_o.addr[31:20] == bbt_pkg::BAND_BASE[31:20]
        && mem_req_o.addr[19:0] == $past(cpu_req_i.addr[24:5]))
        else $error("alias address mistranslated");

    a_size_kept: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i |=>
        mem_req_o.size == $past(cpu_req_i.size))
        else $error("access size changed");

    a_fetch_pass: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i && cpu_req_i.instr |=>
        state == bbt_pkg::BBT_PASS
        && mem_req_o.addr == $past(cpu_req_i.addr))
        else $error("instruction fetch remapped");

    a_bit_range: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        cpu_done_o && $past(state) == bbt_pkg::BBT_RD |->
        cpu_rdata_o == (($past(mem_rdata_i) >> $past(req.addr[6:2]))
                        & 32'h0000_0001))
        else $error("alias read took the wrong byte lane or bit");

    a_req_stands: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        mem_valid_o && !mem_done_i |=>
        mem_valid_o && $stable(mem_req_o))
        else $error("memory request changed before it was answered");

    a_lock_stays: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        mem_lock_o && !mem_done_i |=> mem_lock_o)
        else $error("lock dropped before the memory answered");

    a_read_first: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i && is_alias |=>
        mem_lock_o && !mem_req_o.write)
        else $error("alias access did not start with a read");

    a_wb_write: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_RD && mem_done_i && req.write |=>
        mem_req_o.write && $stable(mem_req_o.addr)
        && $stable(mem_req_o.size))
        else $error("write-back not aimed at the location read");

    a_base_map: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i && is_alias
        && cpu_req_i.addr[24:2] == 23'h00_0000 |=>
        mem_req_o.addr == bbt_pkg::BAND_BASE)
        else $error("lowest alias word not at first band byte");

    a_top_map: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == bbt_pkg::BBT_IDLE && cpu_valid_i && is_alias
        && cpu_req_i.addr[24:2] == 23'h7F_FFFF |=>
        mem_req_o.addr == (bbt_pkg::BAND_BASE | 32'h000F_FFFF))
        else $error("highest alias word not at last band byte");

    a_alias_bound: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        cpu_valid_i && is_alias |->
        cpu_req_i.addr >= bbt_pkg::ALIAS_BASE
        && cpu_req_i.addr[31:2] <= bbt_pkg::ALIAS_LAST[31:2])
        else $error("alias decoded outside the alias window");

endmodule : bbt_bridge

// file: common/bbt_pkg.sv
package bbt_pkg;
    // Region bases and bounds
    localparam logic [31:0] BAND_BASE  = 32'h2000_0000;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ALIAS_LAST = 32'h23FF_FFFC;
    localparam logic [5:0]  ALIAS_TOP  = 6'h08;
    localparam int          BYTE_MUL   = 32;
    localparam int          BIT_MUL    = 4;
    localparam int          BYTE_LSB   = 5;
    localparam int          BYTE_W     = 20;
    localparam int          BIT_LSB    = 2;
    localparam int          BIT_W      = 3;

    // Access size encodings
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [1:0]  size;
        logic [31:0] wdata;
        logic        instr;
    } bbt_req_t;

    typedef enum logic [1:0] {
        BBT_IDLE  = 2'b00,
        BBT_PASS  = 2'b01,
        BBT_RD    = 2'b10,
        BBT_WB    = 2'b11
    } bbt_state_t;
endpackage : bbt_pkg

// file: test/bbt_mem_model.sv
`timescale 1ns/1ps
module bbt_mem_model (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Bridge side
    input  wire logic              mem_valid_i,
    input  wire bbt_pkg::bbt_req_t mem_req_i,
    output logic                   mem_ready_o,
    output logic                   mem_done_o,
    output logic [31:0]            mem_rdata_o
);
    logic [31:0] mem [64];
    logic [3:0]  lane;
    logic [5:0]  w;
    logic [1:0]  s;
    assign mem_ready_o = 1'b1;
    assign w = mem_req_i.addr[7:2];
    assign s = mem_req_i.size;
    assign lane = (s == bbt_pkg::SZ_WORD) ? 4'hF : (s == bbt_pkg::SZ_HALF) ?
        (mem_req_i.addr[1] ? 4'hC : 4'h3) : 4'h1 << mem_req_i.addr[1:0];
    // Random latency; rdata is junk outside an answer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_done_o  <= 1'b0;
            mem_rdata_o <= 32'h0;
        end else begin
            mem_done_o  <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_valid_i && !mem_done_o && $urandom_range(2) == 0) begin
                mem_done_o  <= 1'b1;
                mem_rdata_o <= mem[w];
                for (int b = 0; b < 4; b++) begin
                    if (mem_req_i.write && lane[b])
                        mem[w][8*b +: 8] <= mem_req_i.wdata[8*b +: 8];
                end
            end
        end
    end
endmodule : bbt_mem_model

// file: test/bbt_bridge_tb.sv
`timescale 1ns/1ps
module bbt_bridge_tb;
    logic              clk_i, resetn_i, cpu_valid_i, cpu_ready_o, cpu_done_o;
    logic              mem_valid_o, mem_lock_o, mem_ready_i, mem_done_i;
    bbt_pkg::bbt_req_t cpu_req_i, mem_req_o;
    logic [31:0]       cpu_rdata_o, mem_rdata_i, r, ma;
    logic [31:0]       sh [64];
    logic [19:0]       x;
    int                fails, checks_done, cycles;
    bbt_bridge i_bbt_bridge (.clk_i(clk_i), .resetn_i(resetn_i),
        .cpu_valid_i(cpu_valid_i), .cpu_req_i(cpu_req_i),
        .cpu_ready_o(cpu_ready_o), .cpu_done_o(cpu_done_o),
        .cpu_rdata_o(cpu_rdata_o), .mem_valid_o(mem_valid_o),
        .mem_req_o(mem_req_o), .mem_lock_o(mem_lock_o),
        .mem_ready_i(mem_ready_i), .mem_done_i(mem_done_i),
        .mem_rdata_i(mem_rdata_i));
    bbt_mem_model i_bbt_mem_model (.clk_i(clk_i), .resetn_i(resetn_i),
        .mem_valid_i(mem_valid_o), .mem_req_i(mem_req_o),
        .mem_ready_o(mem_ready_i), .mem_done_o(mem_done_i),
        .mem_rdata_o(mem_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // One request; notes the first memory address and checks every phase
    task automatic access(input logic [31:0] a, input logic w,
                          input logic [1:0] s, input logic [31:0] d,
                          input logic f);
        int n;
        n = 0;
        @(posedge clk_i);
        cpu_valid_i <= 1'b1;
        cpu_req_i   <= '{addr: a, write: w, size: s, wdata: d, instr: f};
        @(posedge clk_i);
        cpu_valid_i <= 1'b0;
        ma = 32'hFFFF_FFFF;
        while (cpu_done_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
            if (mem_valid_o === 1'b1) begin
                if (ma === 32'hFFFF_FFFF) ma = mem_req_o.addr;
                chk(32'(mem_req_o.size), 32'(s));
                chk(32'(mem_lock_o), 32'(a[31:25] == 7'h11 && !f));
                chk(32'(cpu_ready_o), 32'h0);
            end
        end
        chk(32'(cpu_done_o), 32'h1);
        chk(32'(cpu_ready_o), 32'h1);
        r = cpu_rdata_o;
    endtask : access
    // Band byte that holds the bit an alias word stands for
    function automatic logic [31:0] exp_band(input logic [31:0] a);
        return bbt_pkg::BAND_BASE + ((a - bbt_pkg::ALIAS_BASE) >> 5);
    endfunction : exp_band
    task automatic bit_op(input logic [19:0] x, input logic [2:0] b,
                          input logic w, input logic [31:0] d);
        logic [31:0] aa;
        aa = 32'h2200_0000 + 32'(x) * 32 + 32'(b) * 4;
        access(aa, w, 2'($urandom_range(2)), d, 1'b0);
        chk(ma, exp_band(aa));
        if (w) sh[x[7:2]][{x[1:0], b}] = d[0];
        else chk(r, {31'h0, sh[x[7:2]][{x[1:0], b}]});
        access(32'h2000_0000 + {12'h0, x[19:2], 2'h0}, 1'b0,
               bbt_pkg::SZ_WORD, 32'h0, 1'b0);
        chk(r, sh[x[7:2]]);
    endtask : bit_op
    initial begin
        resetn_i    = 1'b0;
        cpu_valid_i = 1'b0;
        cpu_req_i   = '0;
        void'($urandom(85));
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            x = (i < 4) ? 20'(i * 4) : 20'hFFFF0 + 20'((i - 4) * 4);
            sh[x[7:2]] = $urandom;
            access(32'h2000_0000 + 32'(x), 1'b1, bbt_pkg::SZ_WORD,
                   sh[x[7:2]], 1'b0);
        end
        bit_op(20'h0, 3'h0, 1'b1, 32'hFF);
        bit_op(20'h0, 3'h0, 1'b0, 32'h0);
        bit_op(20'h0, 3'h0, 1'b1, 32'hFFFF_FFFE);
        bit_op(20'h0, 3'h0, 1'b0, 32'h0);
        bit_op(20'hFFFFF, 3'h7, 1'b1, 32'h01);
        bit_op(20'hFFFFF, 3'h7, 1'b1, 32'h0E);
        bit_op(20'hFFFFF, 3'h7, 1'b0, 32'h0);
        $display("corner tests done");
        for (int t = 0; t < 60; t++) begin
            x = 20'($urandom_range(15)) | ($urandom_range(1) ? 20'hFFFF0 : 20'h0);
            bit_op(x, 3'($urandom_range(7)), 1'($urandom), $urandom);
            $display("random test %0d done", t);
        end
        access(32'h2200_0004, 1'b0, bbt_pkg::SZ_WORD, 32'h0, 1'b1);
        chk(ma, 32'h2200_0004);
        chk(r, sh[1]);
        $display("fetch test done");
        give_verdict();
    end
endmodule : bbt_bridge_tb
